/* verilog/wdg_lp_defines.svh */
`ifndef WDG_LP_DEFINES_SVH
`define WDG_LP_DEFINES_SVH

// Oscillator cycles per counter decrement
`define WDG_PRESCALE 16384
// Restart delays in CPU clocks
`define WDG_DLY_SHORT 256
`define WDG_DLY_LONG 4096
// Counter reset value and trip value
`define WDG_CNT_RST 7'h7F
`define WDG_CNT_TRIP 7'h40
// Register offsets
`define WDG_ADDR_CTRL 2'h0
`define WDG_ADDR_STAT 2'h1
// Field positions
`define WDG_ACT_BIT 7
`define WDG_T6_BIT 6
`define WDG_STAT_BUSY_BIT 3

`endif

/* verilog/wdg_lp_pkg.sv */
`default_nettype none

package wdg_lp_pkg;

  // Watchdog power state
  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_HALT_DEC = 3'b001,
    ST_HALT     = 3'b010,
    ST_AHALT    = 3'b011,
    ST_WAKE_DLY = 3'b100
  } wdg_state_t;

endpackage

`default_nettype wire

/* verilog/watchdog_low_power_behaviour.sv */
// Function
// - Slow and wait leave watchdog fully running
// - Halt, no timebase, no option: halt
// - Halt entry decrements once then freezes
// - External wake from halt delays restart
// - Reset from halt disables unless hardware
// - Halt, no timebase, option set: reset
// - Halt with timebase: active-halt, counter stops
// - Wake from active-halt resumes counting immediately
// - Reset ending active-halt delays restart
// - Hardware option forces watchdog always active
// - Active watchdog resets on 40h to 3Fh
// - Counter decrements every 16384 cycles in run, active or not
// - Reset disables; activation sticks until reset
`include "wdg_lp_defines.svh"
`default_nettype none

module watchdog_low_power_behaviour #(
  parameter int unsigned PRESCALE = `WDG_PRESCALE,
  parameter int unsigned DLY_SHORT = `WDG_DLY_SHORT,
  parameter int unsigned DLY_LONG = `WDG_DLY_LONG
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Power control and wake events
  input wire logic halt_exec_i,
  input wire logic timebase_interrupt_enable_i,
  input wire logic halt_reset_option_i,
  input wire logic hw_watchdog_option_i,
  input wire logic long_delay_sel_i,
  input wire logic ext_irq_i,
  input wire logic timebase_irq_i,
  // Status outputs
  output logic wdg_reset_o,
  output wdg_lp_pkg::wdg_state_t state_o
);
  import wdg_lp_pkg::*;

  localparam int unsigned PW = $clog2(PRESCALE);
  localparam int unsigned DW = $clog2(DLY_LONG + 1);

  wdg_state_t state_q;
  logic [PW-1:0] pre_q;
  logic [DW-1:0] dly_q;
  logic [6:0] cnt_q;
  logic act_q;
  logic rst_q;
  logic [7:0] rdata_q;

  logic tick;
  logic active;
  logic ctrl_wr;
  logic [DW-1:0] dly_last;
  logic halt_req;
  logic trip;
  logic sw_trip;

  // Decode and shared terms
  assign ctrl_wr = wr_i && (addr_i == `WDG_ADDR_CTRL);
  assign tick = (pre_q == PW'(PRESCALE - 1));
  assign dly_last = long_delay_sel_i ? DW'(DLY_LONG - 1) : DW'(DLY_SHORT - 1);
  assign halt_req = halt_exec_i && (state_q == ST_RUN);
  assign active = act_q || hw_watchdog_option_i;

  // trip on 40h to 3Fh while running
  // A halt taken on this edge wins, so halt entry never adds a last tick
  assign trip = active && (state_q == ST_RUN) && tick && !ctrl_wr && !halt_req
    && (cnt_q == `WDG_CNT_TRIP);
  // Software reset by writing T6 clear with watchdog active
  assign sw_trip = ctrl_wr && !wdata_i[`WDG_T6_BIT] && (active || wdata_i[`WDG_ACT_BIT]);

  // Prescaler, frozen only while the oscillator is stopped in halt
  // prescale runs in every state except halt
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_q <= '0;
    end else if (state_q != ST_HALT) begin
      pre_q <= tick ? '0 : pre_q + PW'(1);
    end
  end

  // Power state sequencing
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // reset returns to delayed restart, disabled
      state_q <= ST_WAKE_DLY;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (halt_exec_i) begin
            if (timebase_interrupt_enable_i) begin
              state_q <= ST_AHALT;
            end else if (!halt_reset_option_i) begin
              state_q <= ST_HALT_DEC;
            end
          end
        end
        ST_HALT_DEC: begin
          state_q <= ST_HALT;
        end
        ST_HALT: begin
          if (ext_irq_i) begin
            state_q <= ST_WAKE_DLY;
          end
        end
        ST_AHALT: begin
          if (ext_irq_i || timebase_irq_i) begin
            state_q <= ST_RUN;
          end
        end
        ST_WAKE_DLY: begin
          // Also ends if the select shrinks the delay mid-count
          if (dly_q >= dly_last) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Restart delay counter
  // delay length from input select
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dly_q <= '0;
    end else if (state_q == ST_WAKE_DLY && dly_q < dly_last) begin
      dly_q <= dly_q + DW'(1);
    end else begin
      dly_q <= '0;
    end
  end

  // Watchdog counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= `WDG_CNT_RST;
    end else if (ctrl_wr) begin
      cnt_q <= wdata_i[6:0];
    end else if (state_q == ST_HALT_DEC) begin
      cnt_q <= cnt_q - 7'h01;
    // run mode counting covers slow and wait
    // no last tick on the halt edge
    end else if (state_q == ST_RUN && tick && !halt_req) begin
      cnt_q <= cnt_q - 7'h01;
    end
  end

  // Activation bit
  // set by software, cleared only by reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_q <= 1'b0;
    end else if (ctrl_wr && wdata_i[`WDG_ACT_BIT]) begin
      act_q <= 1'b1;
    end
  end

  // Reset request pulse
  // halt with option set and timebase interrupt off requests reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q <= 1'b0;
    end else begin
      rst_q <= trip || sw_trip || (halt_req && !timebase_interrupt_enable_i && halt_reset_option_i);
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i && addr_i == `WDG_ADDR_CTRL) begin
      rdata_q <= {active, cnt_q};
    end else if (rd_i && addr_i == `WDG_ADDR_STAT) begin
      rdata_q <= {4'h0, (state_q == ST_WAKE_DLY), state_q};
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Outputs straight from flops
  assign rdata_o = rdata_q;
  assign wdg_reset_o = rst_q;
  assign state_o = state_q;

  // Checks
  // halt with option set
  halt_reset_req_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_req && !timebase_interrupt_enable_i && halt_reset_option_i |=> wdg_reset_o && state_q == ST_RUN)
    else $error("halt with option did not reset");

  halt_enter_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_req && !timebase_interrupt_enable_i && !halt_reset_option_i && !ctrl_wr
    |=> state_q == ST_HALT_DEC && !wdg_reset_o ##1 state_q == ST_HALT)
    else $error("plain halt entry wrong");

  halt_dec_once_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_HALT_DEC && !ctrl_wr |=> cnt_q == $past(cnt_q) - 7'h01)
    else $error("halt entry decrement missing");

  halt_frozen_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_HALT && !ctrl_wr |=> $stable(cnt_q) && !wdg_reset_o)
    else $error("counter moved in halt");

  ahalt_enter_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_req && timebase_interrupt_enable_i && !ctrl_wr
    |=> state_q == ST_AHALT && !wdg_reset_o && $stable(cnt_q))
    else $error("active-halt entry wrong");

  ahalt_wake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_AHALT && (ext_irq_i || timebase_irq_i) |=> state_q == ST_RUN)
    else $error("active-halt wake delayed");

  halt_wake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_HALT && ext_irq_i |=> state_q == ST_WAKE_DLY && dly_q == '0)
    else $error("halt wake skipped delay");

  wake_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_WAKE_DLY && !ctrl_wr |=> $stable(cnt_q) && dly_q <= dly_last)
    else $error("counter moved during delay");

  hw_trip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    hw_watchdog_option_i && state_q == ST_RUN && tick && !ctrl_wr && !halt_exec_i && cnt_q == 7'h40
    |=> wdg_reset_o && cnt_q == 7'h3F)
    else $error("hardware watchdog did not trip");

  run_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_RUN && tick && !ctrl_wr && !halt_exec_i |=> cnt_q == $past(cnt_q) - 7'h01)
    else $error("run decrement missing");

  act_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    act_q |=> act_q)
    else $error("activation bit cleared");

  // counter and reset still in active-halt
  ahalt_silent_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_AHALT && !ctrl_wr |=> $stable(cnt_q) && !wdg_reset_o)
    else $error("counter moved in active-halt");

  idle_silent_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !act_q && !hw_watchdog_option_i && !ctrl_wr && !halt_exec_i |=> !wdg_reset_o)
    else $error("disabled watchdog reset");

  hw_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    rd_i && addr_i == `WDG_ADDR_CTRL && hw_watchdog_option_i |=> rdata_o[`WDG_ACT_BIT])
    else $error("hardware option not shown active");

  // software reset honoured with hardware option
  hw_soft_trip_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_wr && !wdata_i[`WDG_T6_BIT] && hw_watchdog_option_i |=> wdg_reset_o)
    else $error("hardware option soft reset missing");

  // restart delay counts one clock at a time
  wake_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_WAKE_DLY && dly_q < dly_last
    |=> state_q == ST_WAKE_DLY && dly_q == $past(dly_q) + DW'(1))
    else $error("restart delay count wrong");

  wake_end_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_WAKE_DLY && dly_q >= dly_last |=> state_q == ST_RUN && dly_q == '0)
    else $error("restart delay did not end");

  // Main scenarios
  cov_halt_wake_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_HALT ##1 state_q == ST_WAKE_DLY);
  cov_ahalt_wake_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    state_q == ST_AHALT ##1 state_q == ST_RUN);
  cov_trip_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    trip ##1 wdg_reset_o);
  cov_soft_trip_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    sw_trip ##1 wdg_reset_o);
  cov_halt_reset_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    halt_req && halt_reset_option_i && !timebase_interrupt_enable_i ##1 wdg_reset_o);

endmodule

`default_nettype wire

/* verif/watchdog_low_power_behaviour_tb.sv */
`default_nettype none
module watchdog_low_power_behaviour_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdg_lp_pkg::*;
  localparam int P = 16;
  localparam int DS = 4;
  localparam int DL = 8;
  logic clk_i, rst_b_i, wr_i, rd_i, halt, tbe, hro, hwo, lds, ext, tbi, wdg_rst;
  logic rd_d = 1'b0;
  logic [1:0] addr;
  logic [7:0] wdata, rdata;
  logic [23:0] q[$];
  wdg_state_t state;
  int failures = 0;
  int cmp_count = 0;
  int seed = 55428;
  int n;

  watchdog_low_power_behaviour #(.PRESCALE(P), .DLY_SHORT(DS), .DLY_LONG(DL)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .halt_exec_i(halt), .timebase_interrupt_enable_i(tbe), .halt_reset_option_i(hro),
    .hw_watchdog_option_i(hwo), .long_delay_sel_i(lds), .ext_irq_i(ext), .timebase_irq_i(tbi),
    .wdg_reset_o(wdg_rst), .state_o(state));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(string s, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  // Check a cycle count lies in a window
  task automatic rng(string s, int v, int lo, int hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      failures++;
      $display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, v);
    end
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read and note the accepted range of masked data
  task automatic rd(logic [1:0] a, logic [7:0] m, logic [7:0] lo, logic [7:0] hi);
    q.push_back({m, lo, hi});
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Wait for a reset pulse or a state; n is 0 when none came
  task automatic wt(bit r, wdg_state_t e, int lim, output int n);
    for (n = 1; n <= lim; n++) begin
      @(negedge clk_i);
      if (r ? wdg_rst === 1'b1 : state === e) break;
    end
    if (n > lim) n = 0;
    @(posedge clk_i);
  endtask

  task automatic hlt(wdg_state_t e, logic r);
    halt <= 1'b1;
    @(posedge clk_i);
    halt <= 1'b0;
    @(negedge clk_i);
    chk("state", 8'(e), 8'(state));
    chk("reset", 8'(r), 8'(wdg_rst));
    @(posedge clk_i);
  endtask

  // Timebase wake when t is set, external wake otherwise
  task automatic wake(bit t, wdg_state_t e);
    tbi <= t;
    ext <= ~t;
    @(posedge clk_i);
    tbi <= 1'b0;
    ext <= 1'b0;
    @(negedge clk_i);
    chk("state", 8'(e), 8'(state));
    @(posedge clk_i);
  endtask

  task automatic do_rst(int c);
    int d;
    lds <= 1'($random(seed));
    rst_b_i <= 1'b0;
    repeat (c) @(posedge clk_i);
    chk("state", 8'(ST_WAKE_DLY), 8'(state));
    rst_b_i <= 1'b1;
    d = lds ? DL : DS;
    wt(0, ST_RUN, 4 * DL, n);
    rng("delay", n, d - 1, d + 2);
  endtask

  // Take the oldest read note when data appears
  always @(posedge clk_i) begin
    if (rd_d) begin : mon
      logic [23:0] e;
      e = q.pop_front();
      cmp_count++;
      if ((((rdata & e[23:16]) >= e[15:8]) && ((rdata & e[23:16]) <= e[7:0])) !== 1'b1) begin
        failures++;
        $display("mismatch rdata expected %h..%h seen %h", e[15:8], e[7:0], rdata);
      end
    end
    rd_d <= rd_i;
  end

  // Hang guard
  initial begin
    #(40 * 10000);
    failures++;
    end_of_test();
  end

  // Scenarios
  initial begin
    {rst_b_i, wr_i, rd_i, halt, tbe, hro, hwo, lds, ext, tbi} = '0;
    addr = 2'h0;
    wdata = 8'h00;
    do_rst(10);
    rd(2'h0, 8'h80, 8'h00, 8'h00);
    rd(2'h2, 8'hFF, 8'h00, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h1, 8'h07, 8'h00, 8'h00);
    wr(2'h0, 8'h42);
    wt(1, ST_RUN, 3 * P + 1, n);
    rng("no trip", n, 0, 0);
    rd(2'h0, 8'hFF, 8'h3E, 8'h40);
    $display("free run done");
    hwo <= 1'b1;
    rd(2'h0, 8'h80, 8'h80, 8'h80);
    wr(2'h0, 8'h3F);
    wt(1, ST_RUN, 3, n);
    rng("soft trip", n, 1, 2);
    do_rst(2);
    rd(2'h0, 8'h80, 8'h80, 8'h80);
    hwo <= 1'b0;
    do_rst(2);
    $display("hardware option done");
    wr(2'h0, 8'hC5);
    rd(2'h0, 8'hFF, 8'hC4, 8'hC5);
    wr(2'h0, 8'h45);
    rd(2'h0, 8'h80, 8'h80, 8'h80);
    wr(2'h0, 8'hC1);
    wt(1, ST_RUN, 2 * P + 3, n);
    rng("trip", n, P + 1, 2 * P + 3);
    do_rst(2);
    wr(2'h0, 8'hBF);
    wt(1, ST_RUN, 3, n);
    rng("soft trip", n, 1, 2);
    do_rst(2);
    $display("activation done");
    hro <= 1'b1;
    hlt(ST_RUN, 1'b1);
    hro <= 1'b0;
    wr(2'h0, 8'hC2);
    hlt(ST_HALT_DEC, 1'b0);
    wt(1, ST_RUN, 4 * P, n);
    rng("halt trip", n, 0, 0);
    rd(2'h0, 8'hFF, 8'hC0, 8'hC1);
    rd(2'h1, 8'h07, 8'h02, 8'h02);
    wake(1'b0, ST_WAKE_DLY);
    wt(0, ST_RUN, 4 * DL, n);
    rng("wake delay", n, (lds ? DL : DS) - 2, (lds ? DL : DS) + 1);
    wt(1, ST_RUN, 2 * P + 3, n);
    rng("resume", n, 1, 2 * P + 3);
    do_rst(2);
    $display("halt done");
    tbe <= 1'b1;
    hro <= 1'($random(seed));
    wr(2'h0, 8'hC1);
    hlt(ST_AHALT, 1'b0);
    wt(1, ST_RUN, 4 * P, n);
    rng("ahalt trip", n, 0, 0);
    wake(1'($random(seed)), ST_RUN);
    wt(1, ST_RUN, 2 * P + 3, n);
    rng("resume", n, 1, 2 * P + 3);
    do_rst(2);
    hwo <= 1'b1;
    hlt(ST_AHALT, 1'b0);
    do_rst(2);
    rd(2'h0, 8'h80, 8'h80, 8'h80);
    {hwo, tbe, hro} <= 3'b000;
    hlt(ST_HALT_DEC, 1'b0);
    do_rst(2);
    rd(2'h0, 8'h80, 8'h00, 8'h00);
    $display("active halt done");
    end_of_test();
  end
endmodule
`default_nettype wire
